// file: logic/fau_abs_unit.sv
// Float absolute value unit with status word and AHB-Lite registers
`timescale 1ns/100ps
// Function
// [RULE_01] Absolute value written to destination when guarded
// [RULE_02] Operands and results are IEEE single floats
// [RULE_03] Denormal source flushed to zero, flag set
// [RULE_04] Raised exceptions set matching status flags
// [RULE_05] Status flags sticky, cleared only by write
// [RULE_06] Flags update with destination write cycle
// [RULE_07] Concurrent flag updates OR with current value
// [RULE_08] Guard bit zero blocks result and flags
// [RULE_09] Absolute value decoded from code 115
// [RULE_10] Flag query returns abs exceptions as vector
// [RULE_11] Query vector matches status flag layout
// [RULE_12] Flag query never alters status flags
// [RULE_13] Denormal query source sets flushed bit
// [RULE_14] Query writes only when guard bit set
// [RULE_15] Flag query decoded from code 116
// [RULE_16] Result after three cycles, slots 1 and 4
// [RULE_17] Signalling NaN quietened with invalid flag
module fau_abs_unit #(
   parameter int DEST_W = 7,
   parameter int LANES  = 2
) (
   input  wire logic                                mclk,
   input  wire logic                                reset_n,
   input  wire logic                                hsel,
   input  wire logic [31:0]                         haddr,
   input  wire logic [1:0]                          htrans,
   input  wire logic                                hwrite,
   input  wire logic [2:0]                          hsize,
   input  wire logic [31:0]                         hwdata,
   input  wire logic                                hready,
   output logic                                     hreadyout,
   output logic                                     hresp,
   output logic [31:0]                              hrdata,
   input  wire logic [LANES-1:0]                    iss_valid,
   input  wire logic [LANES-1:0][fau_pkg::OPC_W-1:0] iss_opcode,
   input  wire logic [LANES-1:0]                    iss_guard,
   input  wire logic [LANES-1:0][31:0]              iss_src,
   input  wire logic [LANES-1:0][DEST_W-1:0]        iss_dest,
   output logic [LANES-1:0]                         wb_valid,
   output logic [LANES-1:0]                         wb_kind,
   output logic [LANES-1:0][DEST_W-1:0]             wb_dest,
   output logic [LANES-1:0][31:0]                   wb_data,
   input  wire logic [fau_pkg::FLAG_W-1:0]          ext_flag_set,
   output logic [fau_pkg::FLAG_W-1:0]               processor_status_word,
   output logic                                     irq
);
   localparam int FW = fau_pkg::FLAG_W;

   logic [FW-1:0]     status_reg;
   logic [FW-1:0]     status_next;
   logic [FW-1:0]     mask_reg;
   logic              en_reg;
   logic              wr_pend_reg;
   logic [7:0]        wr_addr_reg;
   logic [31:0]       rdata_reg;
   logic              irq_reg;
   logic              addr_ok;
   logic [FW-1:0]     lane_set;
   logic [FW-1:0]     clr;
   logic [LANES-1:0]  cm_valid;
   logic [FW-1:0]     cm_flags [LANES];

   // Issue lanes: index 0 is slot 1, index 1 is slot 4
   generate
      for (genvar g = 0; g < LANES; g++) begin : g_lane
         fau_lane_if #(.DEST_W(DEST_W)) ln ();
         assign ln.iss_valid  = iss_valid[g] & en_reg;
         assign ln.iss_opcode = iss_opcode[g];
         assign ln.iss_guard  = iss_guard[g];
         assign ln.iss_src    = iss_src[g];
         assign ln.iss_dest   = iss_dest[g];
         assign cm_valid[g]   = ln.cm_valid;
         assign cm_flags[g]   = ln.cm_flags;
         assign wb_valid[g]   = ln.wb_valid;
         assign wb_kind[g]    = ln.wb_kind;
         assign wb_dest[g]    = ln.wb_dest;
         assign wb_data[g]    = ln.wb_data;
         fau_abs_pipe #(.DEST_W(DEST_W)) u_pipe (
            .mclk    (mclk),
            .reset_n (reset_n),
            .ln      (ln.pipe)
         );
      end
   endgenerate

   // Merge every flag source of this cycle
   always_comb begin
      lane_set = ext_flag_set;                             // [RULE_07]
      for (int i = 0; i < LANES; i++) begin
         if (cm_valid[i])                                  // [RULE_12]
            lane_set = lane_set | cm_flags[i];             // [RULE_04]
      end
   end

   assign clr = (wr_pend_reg && wr_addr_reg == fau_pkg::OFS_STATUS)
                ? hwdata[FW-1:0] : '0;
   // Set wins over a clear in the same cycle
   assign status_next = (status_reg & ~clr) | lane_set;    // [RULE_05]

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         status_reg <= fau_pkg::RST_STATUS;
      else
         status_reg <= status_next;                        // [RULE_06]
   end

   // AHB-Lite address phase
   assign addr_ok = hsel & hready & htrans[1]
                    & (hsize == fau_pkg::HSIZE_WORD);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
      end else begin
         wr_pend_reg <= addr_ok & hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mask_reg <= fau_pkg::RST_MASK;
         en_reg   <= fau_pkg::RST_EN;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == fau_pkg::OFS_MASK)
            mask_reg <= hwdata[FW-1:0];
         if (wr_addr_reg == fau_pkg::OFS_CTRL)
            en_reg <= hwdata[fau_pkg::CTRL_EN];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= '0;
      end else if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            fau_pkg::OFS_STATUS: rdata_reg <= {25'h0, status_reg};
            fau_pkg::OFS_MASK:   rdata_reg <= {25'h0, mask_reg};
            fau_pkg::OFS_CTRL:   rdata_reg <= {31'h0, en_reg};
            default:             rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(status_next & mask_reg);
   end

   assign hreadyout             = 1'b1;
   assign hresp                 = 1'b0;
   assign hrdata                = rdata_reg;
   assign processor_status_word = status_reg;
   assign irq                   = irq_reg;

   // Checks on lane 0 and on the status word
   a_result_latency: // [RULE_16]
   assert property (@(posedge mclk) disable iff (!reset_n)
      iss_valid[0] && en_reg && iss_guard[0]
      && iss_opcode[0] == fau_pkg::OPC_ABS |-> ##3 wb_valid[0]
      && !wb_kind[0])
      else $error("abs result not after three cycles");

   a_guard_blocks: // [RULE_08]
   assert property (@(posedge mclk) disable iff (!reset_n)
      !(iss_valid[0] && iss_guard[0]) |-> ##3 !wb_valid[0])
      else $error("write without true guard");

   a_abs_magnitude: // [RULE_01]
   assert property (@(posedge mclk) disable iff (!reset_n)
      wb_valid[0] && !wb_kind[0] && wb_data[0][30:23] != 8'hFF
      |-> !wb_data[0][31])
      else $error("abs result negative");

   a_flush_zero: // [RULE_03]
   assert property (@(posedge mclk) disable iff (!reset_n)
      iss_valid[0] && en_reg && iss_guard[0]
      && iss_opcode[0] == fau_pkg::OPC_ABS
      && iss_src[0][30:23] == 8'h00 && iss_src[0][22:0] != 23'h0
      |-> ##3 wb_data[0] == 32'h0000_0000
      && processor_status_word[fau_pkg::FLG_INPUT_FLUSHED])
      else $error("denormal not flushed");

   a_query_vector: // [RULE_13]
   assert property (@(posedge mclk) disable iff (!reset_n)
      iss_valid[0] && en_reg && iss_guard[0]
      && iss_opcode[0] == fau_pkg::OPC_FLAGS
      && iss_src[0][30:23] == 8'h00 && iss_src[0][22:0] != 23'h0
      |-> ##3 wb_kind[0] && wb_data[0] == 32'h0000_0020)
      else $error("query lacks flushed bit");

   a_flags_sticky: // [RULE_05]
   assert property (@(posedge mclk) disable iff (!reset_n)
      !wr_pend_reg |=> (processor_status_word
      & $past(processor_status_word)) == $past(processor_status_word))
      else $error("sticky flag lost");

   a_query_quiet: // [RULE_12]
   assert property (@(posedge mclk) disable iff (!reset_n)
      cm_valid == '0 && ext_flag_set == '0 && !wr_pend_reg
      |=> $stable(processor_status_word))
      else $error("status changed without cause");

   a_or_merge: // [RULE_07]
   assert property (@(posedge mclk) disable iff (!reset_n)
      1'b1 |=> (processor_status_word & $past(ext_flag_set))
      == $past(ext_flag_set))
      else $error("concurrent flag dropped");

   a_flags_with_dest: // [RULE_06]
   assert property (@(posedge mclk) disable iff (!reset_n)
      wb_valid[0] && !wb_kind[0] && wb_data[0] == fau_pkg::QNAN
      && $past(iss_src[0], 3) != fau_pkg::QNAN
      |-> processor_status_word[fau_pkg::FLG_INVALID])
      else $error("invalid flag not with result");
endmodule : fau_abs_unit

// file: logic/fau_pkg.sv
// Constants shared by the float absolute value unit
package fau_pkg;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned FLAG_W  = 7;
   localparam int unsigned OPC_W   = 8;
   localparam int unsigned LATENCY = 3;
   // Operation codes, 115 and 116
   localparam logic [7:0]  OPC_ABS   = 8'h73;
   localparam logic [7:0]  OPC_FLAGS = 8'h74;
   // Exception flag bit positions
   localparam int unsigned FLG_INX = 1;
   localparam int unsigned FLG_UNF = 2;
   localparam int unsigned FLG_OVF = 3;
   localparam int unsigned FLG_INVALID       = 4;
   localparam int unsigned FLG_INPUT_FLUSHED = 5;
   localparam int unsigned FLG_OFZ = 6;
   // Float fields
   localparam logic [7:0]  EXP_MAX = 8'hFF;
   localparam logic [31:0] QNAN    = 32'hFFFF_FFFF;
   // Register byte offsets
   localparam logic [7:0]  OFS_STATUS = 8'h00;
   localparam logic [7:0]  OFS_MASK   = 8'h04;
   localparam logic [7:0]  OFS_CTRL   = 8'h08;
   localparam int unsigned CTRL_EN    = 0;
   localparam logic [6:0]  RST_STATUS = 7'h00;
   localparam logic [6:0]  RST_MASK   = 7'h00;
   localparam logic        RST_EN     = 1'b1;
   localparam logic [2:0]  HSIZE_WORD = 3'h2;
endpackage : fau_pkg

// file: logic/fau_lane_if.sv
// Issue, commit and writeback signals of one issue lane
`timescale 1ns/100ps
interface fau_lane_if #(parameter int DEST_W = 7);
   logic                          iss_valid;
   logic [fau_pkg::OPC_W-1:0]     iss_opcode;
   logic                          iss_guard;
   logic [fau_pkg::DATA_W-1:0]    iss_src;
   logic [DEST_W-1:0]             iss_dest;
   logic                          cm_valid;
   logic [fau_pkg::FLAG_W-1:0]    cm_flags;
   logic                          wb_valid;
   logic                          wb_kind;
   logic [DEST_W-1:0]             wb_dest;
   logic [fau_pkg::DATA_W-1:0]    wb_data;
   modport pipe (input iss_valid, iss_opcode, iss_guard, iss_src,
                 iss_dest, output cm_valid, cm_flags, wb_valid,
                 wb_kind, wb_dest, wb_data);
   modport host (output iss_valid, iss_opcode, iss_guard, iss_src,
                 iss_dest, input cm_valid, cm_flags, wb_valid,
                 wb_kind, wb_dest, wb_data);
endinterface : fau_lane_if

// file: logic/fau_abs_pipe.sv
// Three-stage absolute value and flag query pipeline for one lane
`timescale 1ns/100ps
module fau_abs_pipe #(
   parameter int DEST_W = 7
) (
   input wire logic mclk,
   input wire logic reset_n,
   fau_lane_if.pipe ln
);
   localparam int DW = fau_pkg::DATA_W;
   localparam int FW = fau_pkg::FLAG_W;

   // Returns {flags, result} of the absolute value
   function automatic logic [FW+DW-1:0] fau_abs(input logic [DW-1:0] x);
      logic [FW-1:0] f;
      logic [DW-1:0] r;
      f = '0;
      r = {1'b0, x[30:0]};                                 // [RULE_01]
      if (x[30:23] == 8'h00 && x[22:0] != 23'h0) begin       // [RULE_02]
         r = '0;                                           // [RULE_03]
         f[fau_pkg::FLG_INPUT_FLUSHED] = 1'b1;             // [RULE_13]
      end else if (x[30:23] == fau_pkg::EXP_MAX && x[22:0] != 23'h0) begin
         r = fau_pkg::QNAN;                                // [RULE_17]
         f[fau_pkg::FLG_INVALID] = ~x[22];                 // [RULE_17]
         if (x[22])
            r = x;
      end
      return {f, r};
   endfunction : fau_abs

   logic [2:0]          v_reg;
   logic [2:0]          kind_reg;
   logic [DEST_W-1:0]   dest_reg [3];
   logic [DW-1:0]       data_reg [3];
   logic [FW-1:0]       flags_reg [3];
   logic                is_abs;
   logic                is_qry;
   logic [FW+DW-1:0]    calc;

   assign is_abs = ln.iss_opcode == fau_pkg::OPC_ABS;      // [RULE_09]
   assign is_qry = ln.iss_opcode == fau_pkg::OPC_FLAGS;    // [RULE_15]
   assign calc   = fau_abs(ln.iss_src);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         v_reg    <= '0;
         kind_reg <= '0;
      end else begin
         v_reg[0]    <= ln.iss_valid & ln.iss_guard           // [RULE_08]
                        & (is_abs | is_qry);                  // [RULE_14]
         kind_reg[0] <= is_qry;
         v_reg[2:1]    <= v_reg[1:0];                         // [RULE_16]
         kind_reg[2:1] <= kind_reg[1:0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 3; i++) begin
            dest_reg[i]  <= '0;
            data_reg[i]  <= '0;
            flags_reg[i] <= '0;
         end
      end else begin
         dest_reg[0]  <= ln.iss_dest;
         data_reg[0]  <= calc[DW-1:0];
         flags_reg[0] <= calc[FW+DW-1:DW];
         for (int i = 1; i < 3; i++) begin
            dest_reg[i]  <= dest_reg[i-1];
            data_reg[i]  <= data_reg[i-1];
            flags_reg[i] <= flags_reg[i-1];
         end
      end
   end

   // Status update is taken at the edge that publishes the result
   assign ln.cm_valid = v_reg[1] & ~kind_reg[1];           // [RULE_06]
   assign ln.cm_flags = flags_reg[1];
   assign ln.wb_valid = v_reg[2];
   assign ln.wb_kind  = kind_reg[2];
   assign ln.wb_dest  = dest_reg[2];
   assign ln.wb_data  = kind_reg[2]                        // [RULE_10]
                        ? {{(DW-FW){1'b0}}, flags_reg[2]}  // [RULE_11]
                        : data_reg[2];
endmodule : fau_abs_pipe

// file: test/fau_regfile.sv
// Register file model that takes the unit's writebacks
`timescale 1ns/100ps
module fau_regfile #(
   parameter int LANES  = 2,
   parameter int DEST_W = 7
) (
   input wire logic                          mclk,
   input wire logic                          reset_n,
   input wire logic [LANES-1:0]              wb_valid,
   input wire logic [LANES-1:0][DEST_W-1:0]  wb_dest,
   input wire logic [LANES-1:0][31:0]        wb_data
);
   logic [31:0] rf [2**DEST_W];
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int r = 0; r < 2**DEST_W; r++) rf[r] <= 32'h0;
      end else begin
         for (int l = 0; l < LANES; l++)
            if (wb_valid[l]) rf[wb_dest[l]] <= wb_data[l];
      end
   end
endmodule : fau_regfile

// file: test/float_abs_value_unit_tb.sv
// Self-checking bench for the float absolute value unit
`timescale 1ns/100ps
module float_abs_value_unit_tb;
   logic             mclk = 1'b0;
   logic             reset_n = 1'b0;
   logic             hsel = 1'b0;
   logic [31:0]      haddr = 32'h0;
   logic [1:0]       htrans = 2'h0;
   logic             hwrite = 1'b0;
   logic [2:0]       hsize = 3'h2;
   logic [31:0]      hwdata = 32'h0;
   wire logic        hready;
   logic             hreadyout, hresp, irq;
   logic [31:0]      hrdata, rd;
   logic [1:0]       iss_valid = 2'h0;
   logic [1:0][7:0]  iss_opcode = '0;
   logic [1:0]       iss_guard = 2'h0;
   logic [1:0][31:0] iss_src = '0;
   logic [1:0][6:0]  iss_dest = '0;
   logic [1:0]       wb_valid, wb_kind;
   logic [1:0][6:0]  wb_dest;
   logic [1:0][31:0] wb_data;
   logic [6:0]       ext_flag_set = 7'h00;
   logic [6:0]       processor_status_word, exp_psw;
   int               fails = 0;
   int               tests_run = 0;
   logic [31:0] src_t [6] = '{32'h4040_0000, 32'hBF80_0000, 32'h0040_0000,
                              32'hFFFF_FFFF, 32'hFFBF_FFFF, 32'hFF7F_FFFF};
   logic [31:0] abs_t [6] = '{32'h4040_0000, 32'h3F80_0000, 32'h0000_0000,
                              32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h7F7F_FFFF};
   logic [6:0]  flg_t [6] = '{7'h00, 7'h00, 7'h20, 7'h00, 7'h10, 7'h00};
   assign hready = hreadyout;
   always #5 mclk = ~mclk;
   fau_abs_unit #(.DEST_W(7), .LANES(2)) u_dut (.mclk(mclk),
      .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .iss_valid(iss_valid), .iss_opcode(iss_opcode),
      .iss_guard(iss_guard), .iss_src(iss_src), .iss_dest(iss_dest),
      .wb_valid(wb_valid), .wb_kind(wb_kind), .wb_dest(wb_dest),
      .wb_data(wb_data), .ext_flag_set(ext_flag_set),
      .processor_status_word(processor_status_word), .irq(irq));
   fau_regfile #(.LANES(2), .DEST_W(7)) u_rf (.mclk(mclk),
      .reset_n(reset_n), .wb_valid(wb_valid), .wb_dest(wb_dest),
      .wb_data(wb_data));
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] q);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      hsize <= fau_pkg::HSIZE_WORD;
      // Address phase stands until ready is seen; if ready never comes, only the watchdog ends it
      do
         @(posedge mclk);
      while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do
         @(posedge mclk);
      while (hready !== 1'b1);
      q = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : ahb
   task put(input int ln, input logic [7:0] opc, input logic g,
            input logic [31:0] src, input logic [6:0] dst);
      iss_opcode[ln] <= opc;
      iss_guard[ln] <= g;
      iss_src[ln] <= src;
      iss_dest[ln] <= dst;
   endtask : put
   task step(input logic [1:0] v);
      iss_valid <= v;
      @(posedge mclk);
      iss_valid <= 2'h0;
      @(posedge mclk);
      #1 chk("early wb_valid", 32'h0, {30'h0, wb_valid});
      @(posedge mclk);
      #1;
   endtask : step
   task op(input int ln, input logic [7:0] opc, input logic g,
           input logic [31:0] src, input logic [6:0] dst,
           input logic ewb, input logic [31:0] ed);
      @(posedge mclk);
      put(ln, opc, g, src, dst);
      step(2'b01 << ln);
      chk("wb_valid", {31'h0, ewb}, {31'h0, wb_valid[ln]});
      if (ewb) begin
         chk("wb_data", ed, wb_data[ln]);
         chk("wb_dest", {25'h0, dst}, {25'h0, wb_dest[ln]});
         chk("wb_kind", {31'h0, opc == fau_pkg::OPC_FLAGS},
             {31'h0, wb_kind[ln]});
      end
   endtask : op
   initial begin
      #200000;
      fails++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      ahb(1'b0, fau_pkg::OFS_STATUS, 32'h0, rd);
      chk("status reset", 32'h0, rd);
      ahb(1'b0, fau_pkg::OFS_MASK, 32'h0, rd);
      chk("mask reset", 32'h0, rd);
      ahb(1'b0, fau_pkg::OFS_CTRL, 32'h0, rd);
      chk("ctrl reset", 32'h1, rd);
      ahb(1'b0, 8'h0C, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      for (int i = 0; i < 6; i++) begin
         op(i % 2, fau_pkg::OPC_FLAGS, 1'b1, src_t[i], 7'(i), 1'b1,
            {25'h0, flg_t[i]});
         chk("psw", 32'h0, {25'h0, processor_status_word});
      end
      op(0, fau_pkg::OPC_ABS, 1'b0, src_t[4], 7'h40, 1'b0, 32'h0);
      op(1, fau_pkg::OPC_FLAGS, 1'b0, src_t[4], 7'h41, 1'b0, 32'h0);
      op(0, 8'h16, 1'b1, src_t[4], 7'h42, 1'b0, 32'h0);
      ahb(1'b1, fau_pkg::OFS_CTRL, 32'h0, rd);
      op(1, fau_pkg::OPC_ABS, 1'b1, src_t[4], 7'h43, 1'b0, 32'h0);
      ahb(1'b1, fau_pkg::OFS_CTRL, 32'h1, rd);
      chk("rf guarded", 32'h0, u_rf.rf[7'h40] | u_rf.rf[7'h41]);
      chk("psw", 32'h0, {25'h0, processor_status_word});
      exp_psw = 7'h00;
      for (int i = 0; i < 6; i++) begin
         op(i % 2, fau_pkg::OPC_ABS, 1'b1, src_t[i], 7'(8 + i), 1'b1,
            abs_t[i]);
         exp_psw = exp_psw | flg_t[i];
         chk("psw", {25'h0, exp_psw},
             {25'h0, processor_status_word});
      end
      @(posedge mclk);
      #1 chk("rf", 32'h7F7F_FFFF, u_rf.rf[7'd13]);
      repeat (10) @(posedge mclk);
      ahb(1'b0, fau_pkg::OFS_STATUS, 32'h0, rd);
      chk("status sticky", 32'h30, rd);
      ahb(1'b1, fau_pkg::OFS_STATUS, 32'h7F, rd);
      #1 chk("psw cleared", 32'h0, {25'h0, processor_status_word});
      @(posedge mclk);
      ext_flag_set <= 7'h40;
      @(posedge mclk);
      ext_flag_set <= 7'h00;
      #1 chk("psw ext", 32'h40, {25'h0, processor_status_word});
      chk("irq masked", 32'h0, {31'h0, irq});
      ahb(1'b1, fau_pkg::OFS_MASK, 32'h10, rd);
      ahb(1'b0, fau_pkg::OFS_MASK, 32'h0, rd);
      chk("mask", 32'h10, rd);
      @(posedge mclk);
      put(0, fau_pkg::OPC_ABS, 1'b1, src_t[2], 7'h50);
      put(1, fau_pkg::OPC_ABS, 1'b1, src_t[4], 7'h51);
      step(2'b11);
      chk("wb both", 32'h3, {30'h0, wb_valid});
      chk("psw both", 32'h70, {25'h0, processor_status_word});
      @(posedge mclk);
      #1 chk("irq raised", 32'h1, {31'h0, irq});
      ahb(1'b1, fau_pkg::OFS_STATUS, 32'h10, rd);
      repeat (2) @(posedge mclk);
      #1 chk("irq cleared", 32'h0, {31'h0, irq});
      chk("psw w1c", 32'h60, {25'h0, processor_status_word});
      final_report();
   end
endmodule : float_abs_value_unit_tb
